// ===== design/stack_string_frame_cfg.svh
// Constants for the stack, string and frame sequencer
`ifndef STACK_STRING_FRAME_CFG_SVH
`define STACK_STRING_FRAME_CFG_SVH

// General register indices, in push-all order
`define SSF_IDX_ACC   3'h0
`define SSF_IDX_CNT   3'h1
`define SSF_IDX_PORT  3'h2
`define SSF_IDX_BASE  3'h3
`define SSF_IDX_SP    3'h4
`define SSF_IDX_FB    3'h5
`define SSF_IDX_SRC   3'h6
`define SSF_IDX_DST   3'h7
`define SSF_IDX_LAST  3'h7
`define SSF_IDX_FIRST 3'h0

// Index and stack steps
`define SSF_STEP_BYTE 16'h0001
`define SSF_STEP_WORD 16'h0002

// Physical address forming
`define SSF_ADDR_W    20
`define SSF_SEG_PAD   4'h0
`define SSF_IO_PAD    4'h0

// Misc widths and values
`define SSF_MASK_NONE 8'h00
`define SSF_MASK_ALL  8'hFF
`define SSF_MASK_ONE  8'h01
`define SSF_LVL_ZERO  8'h00
`define SSF_LVL_ONE   8'h01

`endif

// ===== design/stack_string_frame_pkg.sv
// Types shared by the stack, string and frame sequencer
package stack_string_frame_pkg;

  // Operation select on the start port
  typedef enum logic [2:0] {
    op_none,
    push_all_op,
    pop_all_op,
    port_block_input_op,
    port_block_output_op,
    enter_op,
    frame_release_op
  } op_t;

  // Sequencer states
  typedef enum logic [3:0] {
    st_idle,
    st_push_all,
    st_pop_all,
    st_io_read,
    st_mem_write,
    st_mem_read,
    st_io_write,
    st_enter_push,
    st_enter_loop,
    st_enter_copy,
    st_enter_temp,
    st_enter_end,
    st_frame_release_op,
    st_finish
  } state_t;

endpackage : stack_string_frame_pkg

// ===== design/bus_request_hold.sv
// Holds one bus request in flip-flops until the bus unit acknowledges
`timescale 1ns/1ps
`default_nettype none
`include "stack_string_frame_cfg.svh"

module bus_request_hold #(
  parameter int ADDR_W = `SSF_ADDR_W
) (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              arst_n_in,
  // Request load from the sequencer
  input  wire logic              load_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [15:0]       wdata_in,
  input  wire logic              write_in,
  input  wire logic              io_in,
  input  wire logic              byte_in,
  // Acknowledge from the bus unit
  input  wire logic              ack_in,
  // Held request
  output logic                   req_out,
  output logic [ADDR_W-1:0]      addr_out,
  output logic [15:0]            wdata_out,
  output logic                   write_out,
  output logic                   io_out,
  output logic                   byte_out
);

  // Refuse address widths the address former cannot serve
  if (ADDR_W != `SSF_ADDR_W) begin : g_bad_width
    $error("bus_request_hold: unsupported address width");
  end

  logic              next_req;
  logic [ADDR_W-1:0] next_addr;
  logic [15:0]       next_wdata;
  logic              next_write;
  logic              next_io;
  logic              next_byte;

  // Load wins; acknowledge drops the request
  always_comb begin
    next_req   = req_out;
    next_addr  = addr_out;
    next_wdata = wdata_out;
    next_write = write_out;
    next_io    = io_out;
    next_byte  = byte_out;
    if (load_in) begin
      {next_req, next_addr, next_wdata, next_write, next_io, next_byte} =
        {1'b1, addr_in, wdata_in, write_in, io_in, byte_in};
    end else if (ack_in) begin
      next_req = 1'b0;
    end
  end

  // Request registers
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      {req_out, addr_out, wdata_out, write_out, io_out, byte_out} <= '0;
    end else begin
      {req_out, addr_out, wdata_out, write_out, io_out, byte_out} <=
        {next_req, next_addr, next_wdata, next_write, next_io, next_byte};
    end
  end

endmodule : bus_request_hold

`default_nettype wire

// ===== design/stack_string_frame_ops.sv
// Sequencer for push-all, pop-all, block port transfers and stack frames
// Function
// (RULE1) Push-all stacks the general registers in fixed order.
// (RULE2) Push-all stacks the stack pointer from before it began.
// (RULE3) Pop-all restores in reverse, dropping the stacked pointer.
// (RULE4) Push-all and pop-all change only general registers.
// (RULE5) Block input writes port data at extra segment plus index.
// (RULE6) Block input steps the destination by the direction flag.
// (RULE7) Block output sends source memory to the port, then steps.
// (RULE8) The index step is one for bytes and two for words.
// (RULE9) Frame creation takes a 16-bit size and 8-bit depth.
// (RULE10) Depth zero pushes frame base, copies pointer, allocates.
// (RULE11) Other depths copy depth less one links, then temporary.
// (RULE12) Frame creation ends with base from temporary, pointer less size.
// (RULE13) Frame release reloads pointer then pops the frame base.
// (RULE14) Pushes pre-decrement and pops post-increment by two.
`timescale 1ns/1ps
`default_nettype none
`include "stack_string_frame_cfg.svh"

module stack_string_frame_ops
  import stack_string_frame_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              arst_n_in,
  // Operation start
  input  wire logic              start_in,
  input  wire op_t               op_in,
  input  wire logic              byte_op_in,
  input  wire logic              seg_override_in,
  input  wire logic [15:0]       override_seg_in,
  input  wire logic [15:0]       frame_size_in,
  input  wire logic [7:0]        nest_level_in,
  // Register file and flags
  input  wire logic [15:0]       accumulator_reg_in,
  input  wire logic [15:0]       count_reg_in,
  input  wire logic [15:0]       port_select_reg_in,
  input  wire logic [15:0]       base_reg_in,
  input  wire logic [15:0]       stack_pointer_reg_in,
  input  wire logic [15:0]       frame_base_reg_in,
  input  wire logic [15:0]       source_index_reg_in,
  input  wire logic [15:0]       dest_index_reg_in,
  input  wire logic [15:0]       data_segment_reg_in,
  input  wire logic [15:0]       extra_segment_reg_in,
  input  wire logic [15:0]       stack_segment_reg_in,
  input  wire logic              direction_flag_in,
  // Bus unit
  input  wire logic              bus_ack_in,
  input  wire logic [15:0]       bus_rdata_in,
  output logic                   bus_req_out,
  output logic [`SSF_ADDR_W-1:0] bus_addr_out,
  output logic [15:0]            bus_wdata_out,
  output logic                   bus_write_out,
  output logic                   bus_io_out,
  output logic                   bus_byte_out,
  // Register write-back and status
  output logic                   wb_en_out,
  output logic [2:0]             wb_idx_out,
  output logic [15:0]            wb_data_out,
  output logic                   busy_out,
  output logic                   done_out
);

  // Segment plus offset to physical address
  function automatic logic [`SSF_ADDR_W-1:0] phys(input logic [15:0] seg,
                                                  input logic [15:0] off);
    phys = {seg, `SSF_SEG_PAD} + {`SSF_SEG_PAD, off};
  endfunction : phys

  // Index step by direction and size
  function automatic logic [15:0] step(input logic [15:0] idx, input logic dec,
                                       input logic is_byte);
    logic [15:0] amt;
    amt  = is_byte ? `SSF_STEP_BYTE : `SSF_STEP_WORD; // RULE8
    step = dec ? idx - amt : idx + amt;
  endfunction : step

  // One-hot write-back bit for a register index
  function automatic logic [7:0] bit_of(input logic [2:0] idx);
    bit_of = `SSF_MASK_ONE << idx;
  endfunction : bit_of

  // Lowest pending write-back index
  function automatic logic [2:0] lowest(input logic [7:0] mask);
    lowest = `SSF_IDX_FIRST;
    for (int i = 7; i >= 0; i--) begin
      if (mask[i]) begin
        lowest = 3'(i);
      end
    end
  endfunction : lowest

  state_t      state, next_state;
  logic [15:0] regs [8];
  logic [15:0] next_regs [8];
  logic [15:0] sp_orig, next_sp_orig;
  logic [15:0] temp, next_temp;
  logic [15:0] size, next_size;
  logic [15:0] data, next_data;
  logic [15:0] seg_src, next_seg_src;
  logic [15:0] seg_dst, next_seg_dst;
  logic [15:0] seg_stk, next_seg_stk;
  logic [7:0]  lvl, next_lvl;
  logic [7:0]  mask, next_mask;
  logic [2:0]  cnt, next_cnt;
  logic        dir, next_dir;
  logic        is_byte, next_is_byte;
  logic        issued, next_issued;
  logic        next_wb_en;
  logic [2:0]  next_wb_idx;
  logic [15:0] next_wb_data;
  logic        next_busy;
  logic        next_done;
  logic        ld;
  logic [`SSF_ADDR_W-1:0] ld_addr;
  logic [15:0] ld_wdata;
  logic        ld_write;
  logic        ld_io;
  logic        ld_byte;

  // Next-state logic for the whole sequencer
  always_comb begin
    next_state   = state;
    next_regs    = regs;
    next_sp_orig = sp_orig;
    next_temp    = temp;
    next_size    = size;
    next_data    = data;
    next_seg_src = seg_src;
    next_seg_dst = seg_dst;
    next_seg_stk = seg_stk;
    next_lvl     = lvl;
    next_mask    = mask;
    next_cnt     = cnt;
    next_dir     = dir;
    next_is_byte = is_byte;
    next_issued  = issued;
    next_wb_en   = 1'b0;
    next_wb_idx  = wb_idx_out;
    next_wb_data = wb_data_out;
    next_done    = 1'b0;
    {ld, ld_addr, ld_wdata, ld_write, ld_io, ld_byte} = '0;
    unique case (state)
      st_idle: begin
        if (start_in) begin
          // Snapshot of the general registers only
          next_regs[`SSF_IDX_ACC]  = accumulator_reg_in; // RULE4
          next_regs[`SSF_IDX_CNT]  = count_reg_in;
          next_regs[`SSF_IDX_PORT] = port_select_reg_in;
          next_regs[`SSF_IDX_BASE] = base_reg_in;
          next_regs[`SSF_IDX_SP]   = stack_pointer_reg_in;
          next_regs[`SSF_IDX_FB]   = frame_base_reg_in;
          next_regs[`SSF_IDX_SRC]  = source_index_reg_in;
          next_regs[`SSF_IDX_DST]  = dest_index_reg_in;
          next_sp_orig = stack_pointer_reg_in; // RULE2
          next_seg_src = seg_override_in ? override_seg_in : data_segment_reg_in; // RULE7
          next_seg_dst = extra_segment_reg_in; // RULE5
          next_seg_stk = stack_segment_reg_in;
          next_size    = frame_size_in; // RULE9
          next_lvl     = nest_level_in; // RULE9
          next_dir     = direction_flag_in;
          next_is_byte = byte_op_in;
          next_mask    = `SSF_MASK_NONE;
          next_issued  = 1'b0;
          case (op_in)
            push_all_op: begin
              next_cnt   = `SSF_IDX_FIRST;
              next_state = st_push_all;
            end
            pop_all_op: begin
              next_cnt   = `SSF_IDX_LAST;
              next_state = st_pop_all;
            end
            port_block_input_op:  next_state = st_io_read;
            port_block_output_op: next_state = st_mem_read;
            enter_op:             next_state = st_enter_push;
            frame_release_op:     next_state = st_frame_release_op;
            default:              next_state = st_idle;
          endcase
        end
      end
      st_push_all: begin
        if (!issued) begin
          next_regs[`SSF_IDX_SP] = regs[`SSF_IDX_SP] - `SSF_STEP_WORD; // RULE14
          ld       = 1'b1;
          ld_addr  = phys(seg_stk, next_regs[`SSF_IDX_SP]);
          ld_wdata = (cnt == `SSF_IDX_SP) ? sp_orig : regs[cnt]; // RULE1 RULE2
          ld_write = 1'b1;
          next_issued = 1'b1;
        end else if (bus_ack_in) begin
          next_issued = 1'b0;
          if (cnt == `SSF_IDX_LAST) begin
            next_mask  = bit_of(`SSF_IDX_SP);
            next_state = st_finish;
          end else begin
            next_cnt = cnt + 3'h1; // RULE1
          end
        end
      end
      st_pop_all: begin
        if (!issued) begin
          ld      = 1'b1;
          ld_addr = phys(seg_stk, regs[`SSF_IDX_SP]); // RULE14
          next_issued = 1'b1;
        end else if (bus_ack_in) begin
          next_issued = 1'b0;
          next_regs[`SSF_IDX_SP] = regs[`SSF_IDX_SP] + `SSF_STEP_WORD; // RULE14
          if (cnt != `SSF_IDX_SP) begin
            next_regs[cnt] = bus_rdata_in; // RULE3
          end
          if (cnt == `SSF_IDX_FIRST) begin
            next_mask  = `SSF_MASK_ALL;
            next_state = st_finish;
          end else begin
            next_cnt = cnt - 3'h1; // RULE3
          end
        end
      end
      st_io_read: begin
        if (!issued) begin
          ld      = 1'b1;
          ld_addr = {`SSF_IO_PAD, regs[`SSF_IDX_PORT]}; // RULE5
          ld_io   = 1'b1;
          ld_byte = is_byte;
          next_issued = 1'b1;
        end else if (bus_ack_in) begin
          next_issued = 1'b0;
          next_data   = bus_rdata_in;
          next_state  = st_mem_write;
        end
      end
      st_mem_write: begin
        if (!issued) begin
          ld       = 1'b1;
          ld_addr  = phys(seg_dst, regs[`SSF_IDX_DST]); // RULE5
          ld_wdata = data;
          ld_write = 1'b1;
          ld_byte  = is_byte;
          next_issued = 1'b1;
        end else if (bus_ack_in) begin
          next_issued = 1'b0;
          next_regs[`SSF_IDX_DST] = step(regs[`SSF_IDX_DST], dir, is_byte); // RULE6
          next_mask  = bit_of(`SSF_IDX_DST);
          next_state = st_finish;
        end
      end
      st_mem_read: begin
        if (!issued) begin
          ld      = 1'b1;
          ld_addr = phys(seg_src, regs[`SSF_IDX_SRC]); // RULE7
          ld_byte = is_byte;
          next_issued = 1'b1;
        end else if (bus_ack_in) begin
          next_issued = 1'b0;
          next_data   = bus_rdata_in;
          next_state  = st_io_write;
        end
      end
      st_io_write: begin
        if (!issued) begin
          ld       = 1'b1;
          ld_addr  = {`SSF_IO_PAD, regs[`SSF_IDX_PORT]}; // RULE7
          ld_wdata = data;
          ld_write = 1'b1;
          ld_io    = 1'b1;
          ld_byte  = is_byte;
          next_issued = 1'b1;
        end else if (bus_ack_in) begin
          next_issued = 1'b0;
          next_regs[`SSF_IDX_SRC] = step(regs[`SSF_IDX_SRC], dir, is_byte); // RULE7
          next_mask  = bit_of(`SSF_IDX_SRC);
          next_state = st_finish;
        end
      end
      st_enter_push: begin
        if (!issued) begin
          next_regs[`SSF_IDX_SP] = regs[`SSF_IDX_SP] - `SSF_STEP_WORD; // RULE14
          ld       = 1'b1;
          ld_addr  = phys(seg_stk, next_regs[`SSF_IDX_SP]);
          ld_wdata = regs[`SSF_IDX_FB]; // RULE10
          ld_write = 1'b1;
          next_issued = 1'b1;
        end else if (bus_ack_in) begin
          next_issued = 1'b0;
          next_temp   = regs[`SSF_IDX_SP]; // RULE11
          if (lvl == `SSF_LVL_ZERO) begin
            next_state = st_enter_end; // RULE10
          end else begin
            next_lvl   = lvl - `SSF_LVL_ONE; // RULE11
            next_state = st_enter_loop;
          end
        end
      end
      st_enter_loop: begin
        if (lvl == `SSF_LVL_ZERO) begin
          next_state = st_enter_temp;
        end else if (!issued) begin
          next_regs[`SSF_IDX_FB] = regs[`SSF_IDX_FB] - `SSF_STEP_WORD; // RULE11
          ld      = 1'b1;
          ld_addr = phys(seg_stk, next_regs[`SSF_IDX_FB]);
          next_issued = 1'b1;
        end else if (bus_ack_in) begin
          next_issued = 1'b0;
          next_data   = bus_rdata_in;
          next_state  = st_enter_copy;
        end
      end
      st_enter_copy: begin
        if (!issued) begin
          next_regs[`SSF_IDX_SP] = regs[`SSF_IDX_SP] - `SSF_STEP_WORD; // RULE14
          ld       = 1'b1;
          ld_addr  = phys(seg_stk, next_regs[`SSF_IDX_SP]);
          ld_wdata = data; // RULE11
          ld_write = 1'b1;
          next_issued = 1'b1;
        end else if (bus_ack_in) begin
          next_issued = 1'b0;
          next_lvl    = lvl - `SSF_LVL_ONE;
          next_state  = st_enter_loop;
        end
      end
      st_enter_temp: begin
        if (!issued) begin
          next_regs[`SSF_IDX_SP] = regs[`SSF_IDX_SP] - `SSF_STEP_WORD; // RULE14
          ld       = 1'b1;
          ld_addr  = phys(seg_stk, next_regs[`SSF_IDX_SP]);
          ld_wdata = temp; // RULE11
          ld_write = 1'b1;
          next_issued = 1'b1;
        end else if (bus_ack_in) begin
          next_issued = 1'b0;
          next_state  = st_enter_end;
        end
      end
      st_enter_end: begin
        next_regs[`SSF_IDX_FB] = temp; // RULE10 RULE12
        next_regs[`SSF_IDX_SP] = regs[`SSF_IDX_SP] - size; // RULE10 RULE12
        next_mask  = bit_of(`SSF_IDX_SP) | bit_of(`SSF_IDX_FB);
        next_state = st_finish;
      end
      st_frame_release_op: begin
        if (!issued) begin
          next_regs[`SSF_IDX_SP] = regs[`SSF_IDX_FB]; // RULE13
          ld      = 1'b1;
          ld_addr = phys(seg_stk, regs[`SSF_IDX_FB]);
          next_issued = 1'b1;
        end else if (bus_ack_in) begin
          next_issued = 1'b0;
          next_regs[`SSF_IDX_FB] = bus_rdata_in; // RULE13
          next_regs[`SSF_IDX_SP] = regs[`SSF_IDX_SP] + `SSF_STEP_WORD; // RULE14
          next_mask  = bit_of(`SSF_IDX_SP) | bit_of(`SSF_IDX_FB);
          next_state = st_finish;
        end
      end
      st_finish: begin
        if (mask == `SSF_MASK_NONE) begin
          next_done  = 1'b1;
          next_state = st_idle;
        end else begin
          next_wb_en   = 1'b1;
          next_wb_idx  = lowest(mask);
          next_wb_data = regs[lowest(mask)];
          next_mask    = mask & ~bit_of(lowest(mask));
        end
      end
      default: next_state = st_idle;
    endcase
    next_busy = (next_state != st_idle);
  end

  // Sequencer registers
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state       <= st_idle;
      regs        <= '{default: 16'h0000};
      {sp_orig, temp, size, data, seg_src, seg_dst, seg_stk, lvl, mask, cnt, dir} <= '0;
      {is_byte, issued, wb_en_out, wb_idx_out, wb_data_out, busy_out, done_out} <= '0;
    end else begin
      state       <= next_state;
      regs        <= next_regs;
      {sp_orig, temp, size, data, seg_src, seg_dst, seg_stk, lvl, mask} <=
        {next_sp_orig, next_temp, next_size, next_data, next_seg_src, next_seg_dst,
         next_seg_stk, next_lvl, next_mask};
      {cnt, dir, is_byte, issued, wb_en_out, wb_idx_out, wb_data_out, busy_out, done_out} <=
        {next_cnt, next_dir, next_is_byte, next_issued, next_wb_en, next_wb_idx,
         next_wb_data, next_busy, next_done};
    end
  end

  // Held bus request toward the bus unit
  bus_request_hold #(
    .ADDR_W (`SSF_ADDR_W)
  ) u_bus (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .load_in   (ld),
    .addr_in   (ld_addr),
    .wdata_in  (ld_wdata),
    .write_in  (ld_write),
    .io_in     (ld_io),
    .byte_in   (ld_byte),
    .ack_in    (bus_ack_in),
    .req_out   (bus_req_out),
    .addr_out  (bus_addr_out),
    .wdata_out (bus_wdata_out),
    .write_out (bus_write_out),
    .io_out    (bus_io_out),
    .byte_out  (bus_byte_out)
  );

endmodule : stack_string_frame_ops

`default_nettype wire

// ===== tb/ssf_checker.sv
// Port assertions for the stack, string and frame sequencer
`timescale 1ns/1ps
`default_nettype none
module ssf_checker
  import stack_string_frame_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        arst_n_in,
  input wire logic        start_in,
  input wire op_t         op_in,
  input wire logic [15:0] stack_pointer_reg_in,
  input wire logic [15:0] frame_base_reg_in,
  input wire logic [15:0] port_select_reg_in,
  input wire logic [15:0] stack_segment_reg_in,
  input wire logic        bus_ack_in,
  input wire logic        bus_req_out,
  input wire logic [19:0] bus_addr_out,
  input wire logic        bus_write_out,
  input wire logic        bus_io_out,
  input wire logic        wb_en_out,
  input wire logic [2:0]  wb_idx_out,
  input wire logic [15:0] wb_data_out,
  input wire logic        busy_out
);
  op_t         op_q;
  logic [15:0] sp_q, fb_q, pt_q, ss_q;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // Start operands
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      op_q <= op_none;
      {sp_q, fb_q, pt_q, ss_q} <= '0;
    end else if (start_in && !busy_out) begin
      op_q <= op_in;
      {sp_q, fb_q} <= {stack_pointer_reg_in, frame_base_reg_in};
      {pt_q, ss_q} <= {port_select_reg_in, stack_segment_reg_in};
    end
  end
  req_drop_a: assert property (bus_req_out && bus_ack_in |=> !bus_req_out)
    else $error("req after ack");
  req_hold_a: assert property (bus_req_out && !bus_ack_in |=>
    bus_req_out && $stable(bus_addr_out)) else $error("req changed");
  push_write_a: assert property (op_q == push_all_op && bus_req_out |->
    bus_write_out && !bus_io_out) else $error("push not write");
  pop_read_a: assert property (op_q == pop_all_op && bus_req_out |->
    !bus_write_out && !bus_io_out) else $error("pop not read");
  push_sp_a: assert property (op_q == push_all_op && wb_en_out |->
    wb_idx_out == 3'h4 && wb_data_out == sp_q - 16'h0010) else $error("push sp");
  pop_sp_a: assert property (op_q == pop_all_op && wb_en_out && wb_idx_out == 3'h4 |->
    wb_data_out == sp_q + 16'h0010) else $error("pop sp");
  in_port_a: assert property (op_q == port_block_input_op && bus_req_out && bus_io_out |->
    !bus_write_out && bus_addr_out == {4'h0, pt_q}) else $error("in port");
  frame_release_op_read_a: assert property (op_q == frame_release_op && bus_req_out |->
    !bus_write_out && bus_addr_out == {ss_q, 4'h0} + {4'h0, fb_q}) else $error("release read");
endmodule : ssf_checker
`default_nettype wire

// ===== tb/bus_unit_model.sv
// Memory and port model answering the sequencer bus
`timescale 1ns/1ps
`default_nettype none
module bus_unit_model (
  input  wire logic        clk_in,
  input  wire logic        req_in,
  input  wire logic [19:0] addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        write_in,
  input  wire logic        io_in,
  output var logic         ack_out,
  output var logic [15:0]  rdata_out
);
  logic [15:0] mem [logic [19:0]];
  int          dly = 0;
  int          n = 0;
  initial {ack_out, rdata_out} = '0;
  // Ack after 0 to 2 waits; read data scrambles outside an ack
  always @(posedge clk_in) begin
    #1;
    ack_out = 1'b0;
    rdata_out = ~rdata_out;
    if (!req_in) begin
      dly = n % 3;
      n++;
    end else if (dly > 0) dly--;
    else begin
      ack_out = 1'b1;
      if (write_in && !io_in) mem[addr_in] = wdata_in;
      rdata_out = (!io_in && mem.exists(addr_in)) ? mem[addr_in] : addr_in[15:0] ^ 16'h5A5A;
    end
  end
endmodule : bus_unit_model
`default_nettype wire

// ===== tb/stack_string_frame_ops_tb.sv
// Self-checking bench for the stack, string and frame sequencer
`timescale 1ns/1ps
`default_nettype none
module stack_string_frame_ops_tb;
  import stack_string_frame_pkg::*;
  logic clk_in = 0, arst_n_in = 0, start_in = 0, byte_op_in = 0, ovr = 0, df = 0;
  logic ack, req, wr, io, bt, wb_en, busy, done;
  logic [15:0] r[8], v[8], ds, es, ss, ovs, size, rdata, wdata, wb_data, s, sp, f, st;
  logic [19:0] addr, a;
  logic [2:0] wb_idx;
  logic [7:0] lvl, lv[3] = '{8'h00, 8'h01, 8'h03};
  logic [31:0] seed = 32'hD770E99D;
  op_t op_in = op_none;
  int n_errors = 0, n_tests = 0, cyc = 0, i, k;
  logic [37:0] q_bus[$], q_wb[$];
  always #12.5 clk_in = ~clk_in;
  stack_string_frame_ops dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .start_in(start_in),
    .op_in(op_in), .byte_op_in(byte_op_in), .seg_override_in(ovr), .override_seg_in(ovs),
    .frame_size_in(size), .nest_level_in(lvl), .accumulator_reg_in(r[0]), .count_reg_in(r[1]),
    .port_select_reg_in(r[2]), .base_reg_in(r[3]), .stack_pointer_reg_in(r[4]),
    .frame_base_reg_in(r[5]), .source_index_reg_in(r[6]), .dest_index_reg_in(r[7]),
    .data_segment_reg_in(ds), .extra_segment_reg_in(es), .stack_segment_reg_in(ss),
    .direction_flag_in(df), .bus_ack_in(ack), .bus_rdata_in(rdata), .bus_req_out(req),
    .bus_addr_out(addr), .bus_wdata_out(wdata), .bus_write_out(wr), .bus_io_out(io),
    .bus_byte_out(bt), .wb_en_out(wb_en), .wb_idx_out(wb_idx), .wb_data_out(wb_data),
    .busy_out(busy), .done_out(done));
  bus_unit_model bus (.clk_in(clk_in), .req_in(req), .addr_in(addr), .wdata_in(wdata),
    .write_in(wr), .io_in(io), .ack_out(ack), .rdata_out(rdata));
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction : rnd
  function automatic logic [19:0] pa(input logic [15:0] sg, o);
    return {sg, 4'h0} + {4'h0, o};
  endfunction : pa
  function automatic logic [15:0] mk(input logic [15:0] x);
    return byte_op_in ? {8'h00, x[7:0]} : x;
  endfunction : mk
  task automatic eb(input logic w, p, input logic [19:0] ad, input logic [15:0] x);
    q_bus.push_back({w, p, ad, x});
  endtask : eb
  task automatic ew(input logic [2:0] x, input logic [15:0] y);
    q_wb.push_back({19'h0, x, y});
  endtask : ew
  task automatic check(input logic [37:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  // Start one operation and wait for its end
  task automatic run(input op_t o);
    int t;
    t = 0;
    op_in = o;
    start_in = 1'b1;
    @(posedge clk_in);
    #1 start_in = 1'b0;
    while (done !== 1'b1 && t < 400) begin
      @(posedge clk_in);
      #1 t++;
    end
    if (t == 400) n_errors++;
    check(38'(q_bus.size() + q_wb.size()), 38'h0);
    $display("%s finished", o.name());
  endtask : run
  // Result watcher against the oldest notes
  always @(posedge clk_in) begin
    if (req && ack) check({wr, io, addr, wr ? (bt ? {8'h00, wdata[7:0]} : wdata) : 16'h0000},
      q_bus.size() ? q_bus.pop_front() : 'x);
    if (wb_en) check({19'h0, wb_idx, wb_data}, q_wb.size() ? q_wb.pop_front() : 'x);
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      summarize();
    end
  end
  // Main sequence
  initial begin
    foreach (r[j]) r[j] = rnd();
    {ds, es, ss, ovs, size, lvl} = '0;
    repeat (8) @(posedge clk_in);
    #1 arst_n_in = 1'b1;
    ss = rnd();
    s = r[4];
    v = r;
    for (i = 0; i < 8; i++) eb(1, 0, pa(ss, s - 16'(2 * i + 2)), i == 4 ? s : r[i]);
    ew(3'h4, s - 16'h0010);
    run(push_all_op);
    foreach (r[j]) r[j] = rnd();
    r[4] = s - 16'h0010;
    for (i = 7; i >= 0; i--) eb(0, 0, pa(ss, s - 16'(2 * i + 2)), 16'h0000);
    for (i = 0; i < 8; i++) ew(3'(i), i == 4 ? s : v[i]);
    run(pop_all_op);
    for (i = 0; i < 8; i++) begin
      {ovr, byte_op_in, df} = 3'(i);
      {r[2], r[6], r[7], es, ds, ovs} = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
      st = byte_op_in ? 16'h0001 : 16'h0002;
      eb(0, 1, {4'h0, r[2]}, 16'h0000);
      eb(1, 0, pa(es, r[7]), mk(r[2] ^ 16'h5A5A));
      ew(3'h7, df ? r[7] - st : r[7] + st);
      run(port_block_input_op);
      a = pa(ovr ? ovs : ds, r[6]);
      eb(0, 0, a, 16'h0000);
      eb(1, 1, {4'h0, r[2]}, mk(a[15:0] ^ 16'h5A5A));
      ew(3'h6, df ? r[6] - st : r[6] + st);
      run(port_block_output_op);
    end
    foreach (lv[j]) begin
      {lvl, size, r[4]} = {lv[j], rnd(), rnd()};
      r[5] = r[4] + 16'h0400;
      s = r[4] - 16'h0002;
      f = r[5];
      sp = s;
      eb(1, 0, pa(ss, s), r[5]);
      for (k = 1; k < lvl; k++) begin
        f -= 16'h0002;
        sp -= 16'h0002;
        eb(0, 0, pa(ss, f), 16'h0000);
        eb(1, 0, pa(ss, sp), pa(ss, f) ^ 16'h5A5A);
      end
      if (lvl != 8'h00) begin
        sp -= 16'h0002;
        eb(1, 0, pa(ss, sp), s);
      end
      ew(3'h4, sp - size);
      ew(3'h5, s);
      run(enter_op);
      {r[4], f, r[5]} = {sp - size, r[5], s};
      eb(0, 0, pa(ss, s), 16'h0000);
      ew(3'h4, s + 16'h0002);
      ew(3'h5, f);
      run(frame_release_op);
    end
    summarize();
  end
endmodule : stack_string_frame_ops_tb
bind stack_string_frame_ops ssf_checker chk (.clk_in(clk_in), .arst_n_in(arst_n_in),
  .start_in(start_in), .op_in(op_in), .stack_pointer_reg_in(stack_pointer_reg_in),
  .frame_base_reg_in(frame_base_reg_in), .port_select_reg_in(port_select_reg_in),
  .stack_segment_reg_in(stack_segment_reg_in), .bus_ack_in(bus_ack_in),
  .bus_req_out(bus_req_out), .bus_addr_out(bus_addr_out), .bus_write_out(bus_write_out),
  .bus_io_out(bus_io_out), .wb_en_out(wb_en_out), .wb_idx_out(wb_idx_out),
  .wb_data_out(wb_data_out), .busy_out(busy_out));
`default_nettype wire
